// ==== tom_pkg.sv ====
`default_nettype none

// shared constants and types of the trigger mask engine
package tom_pkg;

  // register addresses, word indices as seen on the register port
  localparam logic [15:0] ADDR_CMD          = 16'h0064; // command word, write only
  localparam logic [15:0] ADDR_GEN_OR_AVAIL = 16'h9dd0; // general or availability
  localparam logic [15:0] ADDR_GEN_OR_SEL   = 16'h9dda; // general or selection
  localparam logic [15:0] ADDR_GEN_AND_AVL  = 16'h9de4; // general and availability
  localparam logic [15:0] ADDR_GEN_AND_SEL  = 16'h9dee; // general and selection
  localparam logic [15:0] ADDR_CH_OR_AVL_LO = 16'h9e02; // channel or availability 0..31
  localparam logic [15:0] ADDR_CH_OR_AVL_HI = 16'h9e03; // channel or availability 32..63
  localparam logic [15:0] ADDR_CH_OR_SEL_LO = 16'h9e0c; // channel or selection 0..31
  localparam logic [15:0] ADDR_CH_OR_SEL_HI = 16'h9e0d; // channel or selection 32..63
  localparam logic [15:0] ADDR_CH_AND_AV_LO = 16'h9e16; // channel and availability 0..31
  localparam logic [15:0] ADDR_CH_AND_AV_HI = 16'h9e17; // channel and availability 32..63
  localparam logic [15:0] ADDR_CH_AND_SL_LO = 16'h9e20; // channel and selection 0..31
  localparam logic [15:0] ADDR_CH_AND_SL_HI = 16'h9e21; // channel and selection 32..63
  localparam logic [15:0] ADDR_EXT_COND     = 16'h9e30; // conditions of the four ttl inputs
  localparam logic [15:0] ADDR_CH_EDGE_LO   = 16'h9e31; // per channel edge mode 0..31
  localparam logic [15:0] ADDR_CH_EDGE_HI   = 16'h9e32; // per channel edge mode 32..63
  localparam logic [15:0] ADDR_DELAY        = 16'h9e33; // trigger delay in clock cycles
  localparam logic [15:0] ADDR_STATUS       = 16'h9e34; // engine status, read only

  // general mask bit positions
  localparam int SOFTWARE_SOURCE_BIT  = 0;
  localparam int EXTERNAL_INPUT_A_BIT = 1;
  localparam int EXTERNAL_INPUT_B_BIT = 2;
  localparam int EXTRA_TTL_A_BIT      = 8;
  localparam int EXTRA_TTL_B_BIT      = 9;
  localparam logic [31:0] NO_SOURCE_CODE = 32'h0000_0000;

  // sources present on this card; input b is digital only, so absent
  localparam logic [31:0] GEN_OR_AVAIL  = 32'h0000_0303;
  localparam logic [31:0] GEN_AND_AVAIL = 32'h0000_0302; // no software source here
  localparam logic [63:0] CH_AVAIL      = 64'h0000_0000_0000_000f;

  // command word bits
  localparam int CMD_START_BIT   = 2;
  localparam int CMD_ENABLE_BIT  = 3;
  localparam int CMD_FORCE_BIT   = 4;
  localparam int CMD_DISABLE_BIT = 5;
  localparam int CMD_STOP_BIT    = 6;

  // values after reset
  localparam logic [31:0] SEL_RST    = 32'h0000_0000;
  localparam logic [31:0] DELAY_RST  = 32'h0000_0000;
  localparam logic [7:0]  COND_RST   = 8'h00;
  localparam logic        ENABLE_RST = 1'b1;

  // condition of one ttl input
  typedef enum logic [1:0] {
    TOM_RISING_EDGE_CONDITION = 2'h0,
    TOM_FALLING_EDGE          = 2'h1,
    TOM_HIGH_LEVEL            = 2'h2,
    TOM_LOW_LEVEL             = 2'h3
  } tom_cond_t;

  // engine states, gray along idle, wait, delay, done
  typedef enum logic [1:0] {
    TOM_IDLE  = 2'h0,
    TOM_WAIT  = 2'h1,
    TOM_DELAY = 2'h3,
    TOM_DONE  = 2'h2
  } tom_state_t;

  // the four ttl trigger inputs
  typedef struct packed {
    logic extra_ttl_b;
    logic extra_ttl_a;
    logic external_input_b;
    logic external_input_a;
  } tom_ext_t;

endpackage : tom_pkg

`default_nettype wire

// ==== tom_trigger_or_mask.sv ====
`default_nettype none

module tom_trigger_or_mask (
  input  wire logic              CLK_SYS,   // system clock, 25 mhz
  input  wire logic              RST_B,     // synchronous reset, active low
  input  wire logic              CE,        // clock enable, freezes all state
  input  wire logic [15:0]       ADDR,      // register index
  input  wire logic [31:0]       WDATA,     // write data
  input  wire logic              WR,        // write strobe
  input  wire logic              RD,        // read strobe
  output logic      [31:0]       RDATA,     // read data, cycle after rd
  input  wire tom_pkg::tom_ext_t EXT_IN,    // ttl trigger inputs
  input  wire logic [63:0]       CH_TRIG,   // channel detector levels
  output logic                   TRIG_OUT,  // final trigger pulse
  output logic                   WAITING,   // engine waits for trigger
  output logic                   TRIGGERED  // trigger issued, until stop or a new start
);

  // selection and configuration registers
  logic [31:0]         gen_or_sel;      // general or selection
  logic [31:0]         gen_and_sel;     // general and selection
  logic [63:0]         ch_or_sel;       // channel or selection
  logic [63:0]         ch_and_sel;      // channel and selection
  logic [63:0]         ch_edge;         // per channel: 1 rising edge, 0 level
  logic [7:0]          ext_cond;        // two bits per ttl input
  logic [31:0]         delay;           // delay in cycles
  logic                trig_enabled;    // global trigger enable

  // engine state
  tom_pkg::tom_state_t state;           // current state
  tom_pkg::tom_state_t next_state;      // state for next edge
  logic [31:0]         delay_cnt;       // remaining delay cycles
  logic [31:0]         next_delay_cnt;  // count for next edge
  logic                next_trig_out;   // pulse for next edge

  // input history for edge conditions
  tom_pkg::tom_ext_t   ext_prev;        // ttl inputs one cycle ago
  logic [63:0]         ch_prev;         // channel levels one cycle ago

  // combining terms
  logic [31:0]         gen_valid;       // general sources with condition met
  logic [63:0]         ch_valid;        // channels with condition met
  logic [31:0]         gen_and_eff;     // and selection, present only
  logic [63:0]         ch_and_eff;      // channel and selection, present only
  logic                or_hit;          // or mask result
  logic                and_hit;         // and mask result
  logic                trig_event;      // gated combined event

  // command decode
  logic                cmd_wr;          // write to command word
  logic                cmd_start;       // start acquisition
  logic                cmd_stop;        // stop acquisition
  logic                cmd_force;       // force trigger
  logic                cmd_enable;      // arm trigger engine
  logic                cmd_disable;     // disarm trigger engine
  logic [31:0]         next_rdata;      // read data for next edge

  // tells whether one ttl input meets its programmed condition
  function automatic logic cond_met(input logic [1:0] c, input logic now, input logic prev);
    logic hit;
    hit = 1'b0;
    unique case (tom_pkg::tom_cond_t'(c))
      tom_pkg::TOM_RISING_EDGE_CONDITION: hit = now & ~prev;
      tom_pkg::TOM_FALLING_EDGE:          hit = ~now & prev;
      tom_pkg::TOM_HIGH_LEVEL:            hit = now;
      tom_pkg::TOM_LOW_LEVEL:             hit = ~now;
    endcase
    return hit;
  endfunction : cond_met

  // command word is a one cycle strobe, never stored
  assign cmd_wr      = WR && (ADDR == tom_pkg::ADDR_CMD);
  assign cmd_start   = cmd_wr & WDATA[tom_pkg::CMD_START_BIT];
  assign cmd_stop    = cmd_wr & WDATA[tom_pkg::CMD_STOP_BIT];
  assign cmd_force   = cmd_wr & WDATA[tom_pkg::CMD_FORCE_BIT];
  assign cmd_enable  = cmd_wr & WDATA[tom_pkg::CMD_ENABLE_BIT];
  assign cmd_disable = cmd_wr & WDATA[tom_pkg::CMD_DISABLE_BIT];

  // general source conditions, one bit per source
  always_comb begin
    gen_valid = tom_pkg::NO_SOURCE_CODE;
    // software source is valid as soon as the engine waits
    gen_valid[tom_pkg::SOFTWARE_SOURCE_BIT] = (state == tom_pkg::TOM_WAIT);
    gen_valid[tom_pkg::EXTERNAL_INPUT_A_BIT] =
      cond_met(ext_cond[1:0], EXT_IN.external_input_a, ext_prev.external_input_a);
    gen_valid[tom_pkg::EXTERNAL_INPUT_B_BIT] =
      cond_met(ext_cond[3:2], EXT_IN.external_input_b, ext_prev.external_input_b);
    gen_valid[tom_pkg::EXTRA_TTL_A_BIT] =
      cond_met(ext_cond[5:4], EXT_IN.extra_ttl_a, ext_prev.extra_ttl_a);
    gen_valid[tom_pkg::EXTRA_TTL_B_BIT] =
      cond_met(ext_cond[7:6], EXT_IN.extra_ttl_b, ext_prev.extra_ttl_b);
  end

  // per channel condition, each channel chooses edge or level
  generate
    for (genvar i = 0; i < 64; i++) begin : g_chan
      assign ch_valid[i] = ch_edge[i] ? (CH_TRIG[i] & ~ch_prev[i]) : CH_TRIG[i];
    end
  endgenerate

  // or mask: any selected, present, valid source
  assign or_hit = |(gen_or_sel & tom_pkg::GEN_OR_AVAIL & gen_valid)
                | |(ch_or_sel & tom_pkg::CH_AVAIL & ch_valid);

  // and mask: every selected present source valid, at least one selected
  assign gen_and_eff = gen_and_sel & tom_pkg::GEN_AND_AVAIL;
  assign ch_and_eff  = ch_and_sel & tom_pkg::CH_AVAIL;
  assign and_hit = (|gen_and_eff | |ch_and_eff)
                 && ((gen_and_eff & ~gen_valid) == 32'h0000_0000)
                 && ((ch_and_eff & ~ch_valid) == 64'h0000_0000_0000_0000);

  // one enable gates every source at once
  assign trig_event = trig_enabled & (or_hit | and_hit);

  // engine sequence: wait, delay, issue
  always_comb begin
    next_state     = state;
    next_delay_cnt = delay_cnt;
    next_trig_out  = 1'b0;
    unique case (state)
      tom_pkg::TOM_IDLE: begin
        // nothing is recognised before start
        if (cmd_start) begin
          next_state = tom_pkg::TOM_WAIT;
        end
      end
      tom_pkg::TOM_WAIT: begin
        // force acts only here, so it is a no-op elsewhere
        if (trig_event || cmd_force) begin
          next_state     = tom_pkg::TOM_DELAY;
          next_delay_cnt = delay;
        end
      end
      tom_pkg::TOM_DELAY: begin
        // count the programmed delay down to zero
        if (delay_cnt == 32'h0000_0000) begin
          next_state    = tom_pkg::TOM_DONE;
          next_trig_out = 1'b1;
        end else begin
          next_delay_cnt = delay_cnt - 32'h0000_0001;
        end
      end
      tom_pkg::TOM_DONE: begin
        // a new start re-arms without a stop first
        if (cmd_start) begin
          next_state = tom_pkg::TOM_WAIT;
        end
      end
    endcase
    // stop wins over everything and drops a pending delay
    if (cmd_stop) begin
      next_state    = tom_pkg::TOM_IDLE;
      next_trig_out = 1'b0;
    end
  end

  // state, delay counter and status outputs
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      state     <= tom_pkg::TOM_IDLE;
      delay_cnt <= tom_pkg::DELAY_RST;
      TRIG_OUT  <= 1'b0;
      WAITING   <= 1'b0;
      TRIGGERED <= 1'b0;
    end else if (CE) begin
      state     <= next_state;
      delay_cnt <= next_delay_cnt;
      TRIG_OUT  <= next_trig_out;
      WAITING   <= (next_state == tom_pkg::TOM_WAIT);
      TRIGGERED <= (next_state == tom_pkg::TOM_DONE);
    end
  end

  // input history for edge conditions
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      ext_prev <= '0;
      ch_prev  <= 64'h0000_0000_0000_0000;
    end else if (CE) begin
      ext_prev <= EXT_IN;
      ch_prev  <= CH_TRIG;
    end
  end

  // global enable, set and cleared by command
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      trig_enabled <= tom_pkg::ENABLE_RST;
    end else if (CE) begin
      // disable wins if software sets both bits in one write
      if (cmd_disable) begin
        trig_enabled <= 1'b0;
      end else if (cmd_enable) begin
        trig_enabled <= 1'b1;
      end
    end
  end

  // mask selection registers, whole word per write
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      gen_or_sel  <= tom_pkg::SEL_RST;
      gen_and_sel <= tom_pkg::SEL_RST;
      ch_or_sel   <= {tom_pkg::SEL_RST, tom_pkg::SEL_RST};
      ch_and_sel  <= {tom_pkg::SEL_RST, tom_pkg::SEL_RST};
    end else if (CE && WR) begin
      // the written word is the bitwise or of source codes
      unique case (ADDR)
        tom_pkg::ADDR_GEN_OR_SEL:   gen_or_sel        <= WDATA;
        tom_pkg::ADDR_GEN_AND_SEL:  gen_and_sel       <= WDATA;
        tom_pkg::ADDR_CH_OR_SEL_LO: ch_or_sel[31:0]   <= WDATA;
        tom_pkg::ADDR_CH_OR_SEL_HI: ch_or_sel[63:32]  <= WDATA;
        tom_pkg::ADDR_CH_AND_SL_LO: ch_and_sel[31:0]  <= WDATA;
        tom_pkg::ADDR_CH_AND_SL_HI: ch_and_sel[63:32] <= WDATA;
        // other addresses do not touch the masks
        default: ;
      endcase
    end
  end

  // condition and delay registers
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      ext_cond <= tom_pkg::COND_RST;
      ch_edge  <= {tom_pkg::SEL_RST, tom_pkg::SEL_RST};
      delay    <= tom_pkg::DELAY_RST;
    end else if (CE && WR) begin
      // condition changes take effect at once; a delay written mid count applies from the next trigger
      unique case (ADDR)
        tom_pkg::ADDR_EXT_COND:   ext_cond       <= WDATA[7:0];
        tom_pkg::ADDR_CH_EDGE_LO: ch_edge[31:0]  <= WDATA;
        tom_pkg::ADDR_CH_EDGE_HI: ch_edge[63:32] <= WDATA;
        tom_pkg::ADDR_DELAY:      delay          <= WDATA;
        default: ;
      endcase
    end
  end

  // read mux; unmapped and write only words read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (ADDR)
      tom_pkg::ADDR_GEN_OR_AVAIL: next_rdata = tom_pkg::GEN_OR_AVAIL;
      tom_pkg::ADDR_GEN_OR_SEL:   next_rdata = gen_or_sel;
      tom_pkg::ADDR_GEN_AND_AVL:  next_rdata = tom_pkg::GEN_AND_AVAIL;
      tom_pkg::ADDR_GEN_AND_SEL:  next_rdata = gen_and_sel;
      tom_pkg::ADDR_CH_OR_AVL_LO: next_rdata = tom_pkg::CH_AVAIL[31:0];
      tom_pkg::ADDR_CH_OR_AVL_HI: next_rdata = tom_pkg::CH_AVAIL[63:32];
      tom_pkg::ADDR_CH_OR_SEL_LO: next_rdata = ch_or_sel[31:0];
      tom_pkg::ADDR_CH_OR_SEL_HI: next_rdata = ch_or_sel[63:32];
      tom_pkg::ADDR_CH_AND_AV_LO: next_rdata = tom_pkg::CH_AVAIL[31:0];
      tom_pkg::ADDR_CH_AND_AV_HI: next_rdata = tom_pkg::CH_AVAIL[63:32];
      tom_pkg::ADDR_CH_AND_SL_LO: next_rdata = ch_and_sel[31:0];
      tom_pkg::ADDR_CH_AND_SL_HI: next_rdata = ch_and_sel[63:32];
      tom_pkg::ADDR_EXT_COND:     next_rdata = {24'h00_0000, ext_cond};
      tom_pkg::ADDR_CH_EDGE_LO:   next_rdata = ch_edge[31:0];
      tom_pkg::ADDR_CH_EDGE_HI:   next_rdata = ch_edge[63:32];
      tom_pkg::ADDR_DELAY:        next_rdata = delay;
      // status: state code, enable, live or and and results
      tom_pkg::ADDR_STATUS:       next_rdata = {27'h000_0000, and_hit, or_hit, trig_enabled, state};
      default:                    next_rdata = 32'h0000_0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      RDATA <= 32'h0000_0000;
    end else if (CE) begin
      RDATA <= RD ? next_rdata : 32'h0000_0000;
    end
  end

endmodule : tom_trigger_or_mask

`default_nettype wire

// ==== tom_or_mask_sva.sv ====
`default_nettype none

// watches the register port and the trigger flags of the engine
module tom_or_mask_sva (
  input wire logic        CLK_SYS,   // system clock
  input wire logic        RST_B,     // synchronous reset, active low
  input wire logic        CE,        // clock enable
  input wire logic [15:0] ADDR,      // register index
  input wire logic [31:0] WDATA,     // write data
  input wire logic        WR,        // write strobe
  input wire logic        RD,        // read strobe
  input wire logic [31:0] RDATA,     // read data
  input wire logic        TRIG_OUT,  // final trigger pulse
  input wire logic        WAITING,   // armed flag
  input wire logic        TRIGGERED  // done flag
);
  logic        ce_q;    // clock enable at last edge
  logic        cmd_q;   // command write taken at last edge
  logic        rd_q;    // read taken at last edge
  logic [15:0] addr_q;  // address at last edge
  logic [31:0] wd_q;    // write data at last edge
  logic        wait_q;  // armed flag before last edge

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  // one stage of the port, so a property sees the request beside its answer
  always_ff @(posedge CLK_SYS) begin
    ce_q   <= CE;
    cmd_q  <= CE && WR && ADDR == tom_pkg::ADDR_CMD;
    rd_q   <= CE && RD;
    addr_q <= ADDR;
    wd_q   <= WDATA;
    wait_q <= WAITING;
  end

  a_rdata_idle_zero: assert property (ce_q && !rd_q |-> RDATA == 32'h0)
    else $error("read data not zero outside the read slot");
  a_gen_avail_read: assert property (
    rd_q && addr_q == tom_pkg::ADDR_GEN_OR_AVAIL |-> RDATA == tom_pkg::GEN_OR_AVAIL)
    else $error("general availability read wrong");
  a_ch_avail_read: assert property (
    rd_q && addr_q == tom_pkg::ADDR_CH_OR_AVL_LO |-> RDATA == tom_pkg::CH_AVAIL[31:0])
    else $error("channel availability read wrong");
  a_trig_pulse_one: assert property (TRIG_OUT && CE |=> !TRIG_OUT)
    else $error("trigger pulse longer than one cycle");
  a_force_idle: assert property (
    cmd_q && wd_q[tom_pkg::CMD_FORCE_BIT] && !wd_q[tom_pkg::CMD_START_BIT] && !wait_q |-> !WAITING)
    else $error("force outside waiting changed state");
  a_start_arms: assert property (
    cmd_q && wd_q[tom_pkg::CMD_START_BIT] && !wd_q[tom_pkg::CMD_STOP_BIT] && !wait_q |-> WAITING)
    else $error("start did not arm the engine");
  a_stop_clears: assert property (
    cmd_q && wd_q[tom_pkg::CMD_STOP_BIT] |-> !WAITING && !TRIGGERED && !TRIG_OUT)
    else $error("stop left the engine busy");
  a_sel_readback: assert property (
    CE && WR && ADDR == tom_pkg::ADDR_GEN_OR_SEL ##1 !WR ##1 RD && ADDR == tom_pkg::ADDR_GEN_OR_SEL
    |=> RDATA == $past(WDATA, 3))
    else $error("general selection read back wrong");
endmodule : tom_or_mask_sva

bind tom_trigger_or_mask tom_or_mask_sva tom_or_mask_sva_inst (
  .CLK_SYS(CLK_SYS), .RST_B(RST_B), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .TRIG_OUT(TRIG_OUT), .WAITING(WAITING), .TRIGGERED(TRIGGERED));

`default_nettype wire

// ==== tom_src_model.sv ====
`default_nettype none

// stands in for the ttl inputs and the channel detectors
module tom_src_model (
  input  wire logic            CLK_SYS,  // system clock
  output var tom_pkg::tom_ext_t EXT_IN,  // ttl trigger levels
  output var logic [63:0]      CH_TRIG   // channel detector levels
);
  timeunit 1ns;
  timeprecision 1ps;

  // quiet lines until a test asks for a level
  initial begin
    EXT_IN  = 4'h0;
    CH_TRIG = 64'h0;
  end

  // levels change only just after an edge, as a synchronous source would
  task automatic drive(input tom_pkg::tom_ext_t e, input logic [63:0] c);
    @(posedge CLK_SYS);
    EXT_IN  <= e;
    CH_TRIG <= c;
  endtask : drive
endmodule : tom_src_model

`default_nettype wire

// ==== testbench.sv ====
`default_nettype none

// drives the register port and trigger sources of the engine
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic              CLK_SYS = 1'b0;  // 25 mhz system clock
  logic              RST_B   = 1'b0;  // synchronous reset, active low
  logic [15:0]       ADDR    = 16'h0; // register index
  logic [31:0]       WDATA   = 32'h0; // write data
  logic              WR      = 1'b0;  // write strobe
  logic              RD      = 1'b0;  // read strobe
  logic              CE      = 1'b1;  // clock enable, low freezes the engine
  logic [31:0]       RDATA;           // read data
  tom_pkg::tom_ext_t EXT_IN;          // ttl levels from the model
  logic [63:0]       CH_TRIG;         // channel levels from the model
  logic              TRIG_OUT;        // final trigger pulse
  logic              WAITING;         // engine armed
  logic              TRIGGERED;       // trigger issued
  int                fails = 0;       // mismatches
  int                check_count = 0; // comparisons
  int                cycles = 0;      // clock cycles so far
  int                n;               // measured trigger latency
  int                dl[2] = '{3, 0}; // delays tried, zero left last
  // source table: mask register, code, {channels, ttl}, expected latency
  logic [15:0]       ta[8] = '{tom_pkg::ADDR_GEN_OR_SEL, tom_pkg::ADDR_GEN_OR_SEL, tom_pkg::ADDR_GEN_OR_SEL,
                               tom_pkg::ADDR_GEN_OR_SEL, tom_pkg::ADDR_GEN_OR_SEL, tom_pkg::ADDR_CH_OR_SEL_LO,
                               tom_pkg::ADDR_CH_OR_SEL_HI, tom_pkg::ADDR_CH_OR_SEL_LO};
  logic [31:0]       tc[8] = '{32'h2, 32'h100, 32'h200, 32'h4, 32'h2, 32'h8, 32'h1, 32'h1};
  logic [67:0]       ti[8] = '{68'h1, 68'h4, 68'h8, 68'h2, 68'h4, 68'h80, 68'h10_0000_0000, 68'h20};
  int                te[8] = '{3, 3, 3, 60, 60, 3, 60, 60};

  always #20 CLK_SYS = ~CLK_SYS;

  tom_trigger_or_mask tom_trigger_or_mask_inst (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .EXT_IN(EXT_IN), .CH_TRIG(CH_TRIG), .TRIG_OUT(TRIG_OUT), .WAITING(WAITING),
    .TRIGGERED(TRIGGERED));

  tom_src_model tom_src_model_inst (.CLK_SYS(CLK_SYS), .EXT_IN(EXT_IN), .CH_TRIG(CH_TRIG));

  // compare one value and keep the tally
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // write, then one idle cycle so the strobe is never set twice in a step
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK_SYS);
    WR    <= 1'b0;
    @(posedge CLK_SYS);
  endtask : wr

  // read data are sampled at the edge that closes their only cycle
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK_SYS);
    RD   <= 1'b0;
    @(posedge CLK_SYS);
    cmp(RDATA, exp);
  endtask : rd

  // cycles until the trigger pulse; 60 means none came
  task automatic lat(input int exp);
    n = 0;
    while (TRIG_OUT !== 1'b1 && n < 60) begin
      @(posedge CLK_SYS);
      n++;
    end
    cmp(32'(n), 32'(exp));
  endtask : lat

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // a hang ends the run as a mismatch
  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    repeat (8) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    // reset values, read only places, unmapped index
    rd(tom_pkg::ADDR_GEN_OR_AVAIL, tom_pkg::GEN_OR_AVAIL);
    rd(tom_pkg::ADDR_CH_OR_AVL_LO, tom_pkg::CH_AVAIL[31:0]);
    rd(tom_pkg::ADDR_CH_OR_AVL_HI, tom_pkg::CH_AVAIL[63:32]);
    rd(tom_pkg::ADDR_GEN_OR_SEL, tom_pkg::NO_SOURCE_CODE);
    rd(tom_pkg::ADDR_STATUS, 32'h4);
    wr(tom_pkg::ADDR_GEN_OR_AVAIL, 32'h0);
    rd(tom_pkg::ADDR_GEN_OR_AVAIL, tom_pkg::GEN_OR_AVAIL);
    rd(16'h1234, 32'h0);
    wr(tom_pkg::ADDR_GEN_OR_SEL, 32'h303);
    rd(tom_pkg::ADDR_GEN_OR_SEL, 32'h303);
    wr(tom_pkg::ADDR_CH_OR_SEL_LO, 32'h8000_0001);
    rd(tom_pkg::ADDR_CH_OR_SEL_LO, 32'h8000_0001);
    wr(tom_pkg::ADDR_CH_OR_SEL_HI, 32'h8);
    rd(tom_pkg::ADDR_CH_OR_SEL_HI, 32'h8);
    $display("test registers finished");
    // software source through the delay, restarted from done
    wr(tom_pkg::ADDR_GEN_OR_SEL, 32'h1);
    foreach (dl[i]) begin
      wr(tom_pkg::ADDR_DELAY, 32'(dl[i]));
      wr(tom_pkg::ADDR_CMD, 32'h4);
      lat(2 + dl[i]);
      cmp({31'h0, TRIGGERED}, 32'h1);
    end
    wr(tom_pkg::ADDR_CMD, 32'h40);
    $display("test software finished");
    // each source alone, absent and unselected ones stay quiet
    for (int i = 0; i < 8; i++) begin
      wr(ta[i], tc[i]);
      wr(tom_pkg::ADDR_CMD, 32'h4);
      tom_src_model_inst.drive(ti[i][3:0], ti[i][67:4]);
      lat(te[i]);
      wr(tom_pkg::ADDR_CMD, 32'h40);
      tom_src_model_inst.drive(4'h0, 64'h0);
    end
    $display("test sources finished");
    // disabled engine ignores sources, force still fires
    wr(tom_pkg::ADDR_GEN_OR_SEL, 32'h1);
    wr(tom_pkg::ADDR_CMD, 32'h20);
    wr(tom_pkg::ADDR_CMD, 32'h4);
    lat(60);
    cmp({31'h0, WAITING}, 32'h1);
    wr(tom_pkg::ADDR_CMD, 32'h10);
    lat(1);
    wr(tom_pkg::ADDR_CMD, 32'h8);
    wr(tom_pkg::ADDR_CMD, 32'h40);
    // force while idle does nothing
    wr(tom_pkg::ADDR_CMD, 32'h10);
    lat(60);
    cmp({31'h0, WAITING}, 32'h0);
    $display("test force finished");
    // a write while the clock enable is low must leave the selection alone
    CE <= 1'b0;
    wr(tom_pkg::ADDR_GEN_OR_SEL, 32'h2);
    CE <= 1'b1;
    rd(tom_pkg::ADDR_GEN_OR_SEL, 32'h1);
    $display("test enable finished");
    wrap_up();
  end
endmodule : testbench

`default_nettype wire
